//--- inc/wri_pkg.sv
// Package for the watchdog register interface: register indices, field
// positions, reset values and the state record of the top module.
// Assumes a 32-bit Avalon-MM slave port with byte addresses, one word per register.
// Notes on behaviour
// - The unlock/control location is write-only and shares its index with the read-only reset status, and writes there never change the status bits.
// - The reset status reads power-on in bit 7, stop recovery in bit 6, watchdog timeout in bit 5, external pin in bit 4, and zero in bits 3 to 0.
// - Reading any of the three reload byte locations returns that byte of the live count, and writing while unlocked loads that byte of the reload value.
// - The reload value is 24 bits held as upper, high and low bytes in the low eight bits of three consecutive word locations.
// - The two locations after the low reload byte are reserved, read as zero and ignore writes.
`default_nettype none
package wri_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] WRI_IDX_CTL_STAT = 12'hff0;
    localparam logic [11:0] WRI_IDX_UPPER = 12'hff1;
    localparam logic [11:0] WRI_IDX_HIGH = 12'hff2;
    localparam logic [11:0] WRI_IDX_LOW = 12'hff3;
    localparam logic [11:0] WRI_IDX_RSVD0 = 12'hff4;
    localparam logic [11:0] WRI_IDX_RSVD1 = 12'hff5;
    localparam logic [11:0] WRI_IDX_IRQ_STS = 12'hffc;
    localparam logic [11:0] WRI_IDX_IRQ_MSK = 12'hffd;
    localparam logic [11:0] WRI_IDX_CFG = 12'hffe;

    // ------------------------------------------------------------
    // Fields and codes
    // ------------------------------------------------------------
    localparam int WRI_CAUSE_LSB = 4;
    // Cause vector positions inside the 4-bit cause field
    localparam int WRI_CAUSE_POR = 3;
    localparam int WRI_CAUSE_STOP = 2;
    localparam int WRI_CAUSE_WDT = 1;
    localparam int WRI_CAUSE_EXT = 0;
    // Interrupt status bits
    localparam int WRI_IRQ_TIMEOUT = 0;
    localparam int WRI_IRQ_BADKEY = 1;
    localparam int WRI_IRQ_W = 2;
    localparam logic [7:0] WRI_KEY_FIRST = 8'h55;
    localparam logic [7:0] WRI_KEY_SECOND = 8'haa;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [23:0] WRI_RELOAD_RST = 24'h00_0400;
    localparam logic [3:0] WRI_CAUSE_RST = 4'h8;
    localparam logic WRI_ENABLE_RST = 1'b1;

    typedef struct packed {
        logic wait_q;
        logic [31:0] rdata;
        logic [23:0] count;
        logic [23:0] reload;
        logic [3:0] cause;
        logic key_stage;
        logic unlocked;
        logic enable;
        logic [WRI_IRQ_W-1:0] irq_sts;
        logic [WRI_IRQ_W-1:0] irq_msk;
        logic irq;
        logic wdt_rst;
        logic ext_prev;
    } wri_state_t;

endpackage
`default_nettype wire

//--- rtl/wri_sync.sv
// Two-stage synchroniser for levels entering the core clock domain.
// Assumes the inputs are slow, level-type signals; no pulse stretching is done.
`timescale 1ns/10ps
`default_nettype none
module wri_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // Only the second stage reads the first
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- rtl/wri_top.sv
// Watchdog register interface: Avalon-MM slave, reload and count registers,
// reset-cause status, unlock sequence, down counter and interrupt.
// Assumes one core clock; the external reset pin is asynchronous to it.
`timescale 1ns/10ps
`default_nettype none
module wri_top
    import wri_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_reset_pin,
    input wire logic stop_recov_evt,
    output logic wdt_reset_req,
    output logic irq
);
    wri_state_t st_r;
    wri_state_t st_nxt;
    logic ext_sync;
    logic [11:0] idx;
    logic req;
    logic accept;
    logic wr_ok;
    logic [3:0] cause_set;
    logic timeout;
    logic refresh;
    logic [WRI_IRQ_W-1:0] irq_set;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    wri_sync #(
        .WIDTH(1)
    ) u_ext_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(ext_reset_pin),
        .sync_out(ext_sync)
    );

    assign idx = avs_address[13:2];
    assign req = avs_read | avs_write;
    // A request completes on the edge where waitrequest is seen low
    assign accept = req & ~st_r.wait_q;
    assign wr_ok = accept & avs_write;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        refresh = 1'b0;
        irq_set = '0;
        cause_set = '0;

        // One wait state: answer is prepared while waitrequest is high
        if (accept)
        begin
            st_nxt.wait_q = 1'b1;
        end
        else if (req)
        begin
            st_nxt.wait_q = 1'b0;
        end
        st_nxt.rdata = '0;
        if (req & st_r.wait_q & avs_read)
        begin
            unique case (idx)
                WRI_IDX_CTL_STAT: st_nxt.rdata[7:0] = {st_r.cause, 4'h0};
                WRI_IDX_UPPER: st_nxt.rdata[7:0] = st_r.count[23:16];
                WRI_IDX_HIGH: st_nxt.rdata[7:0] = st_r.count[15:8];
                WRI_IDX_LOW: st_nxt.rdata[7:0] = st_r.count[7:0];
                WRI_IDX_IRQ_STS: st_nxt.rdata[WRI_IRQ_W-1:0] = st_r.irq_sts;
                WRI_IDX_IRQ_MSK: st_nxt.rdata[WRI_IRQ_W-1:0] = st_r.irq_msk;
                WRI_IDX_CFG: st_nxt.rdata[0] = st_r.enable;
                // reserved and unmapped read as zero
                default: st_nxt.rdata = '0;
            endcase
        end

        // control writes drive the key sequence and the bad-key flag, never the causes
        if (wr_ok && idx == WRI_IDX_CTL_STAT)
        begin
            if (!st_r.key_stage && avs_writedata[7:0] == WRI_KEY_FIRST)
            begin
                st_nxt.key_stage = 1'b1;
            end
            else if (st_r.key_stage && avs_writedata[7:0] == WRI_KEY_SECOND)
            begin
                st_nxt.key_stage = 1'b0;
                st_nxt.unlocked = 1'b1;
                refresh = 1'b1;
            end
            else
            begin
                st_nxt.key_stage = 1'b0;
                irq_set[WRI_IRQ_BADKEY] = 1'b1;
            end
        end

        // reload bytes load only while unlocked; the low byte relocks
        // Relocking on the low byte keeps a stray write from changing the period
        if (wr_ok && st_r.unlocked)
        begin
            unique case (idx)
                WRI_IDX_UPPER: st_nxt.reload[23:16] = avs_writedata[7:0];
                WRI_IDX_HIGH: st_nxt.reload[15:8] = avs_writedata[7:0];
                WRI_IDX_LOW:
                begin
                    st_nxt.reload[7:0] = avs_writedata[7:0];
                    st_nxt.unlocked = 1'b0;
                end
                default: st_nxt.reload = st_r.reload;
            endcase
        end
        if (wr_ok && idx == WRI_IDX_CFG)
        begin
            st_nxt.enable = avs_writedata[0];
        end
        if (wr_ok && idx == WRI_IDX_IRQ_MSK)
        begin
            st_nxt.irq_msk = avs_writedata[WRI_IRQ_W-1:0];
        end

        // count down, expire at zero unless refreshed
        timeout = st_r.enable & (st_r.count == '0) & ~refresh;
        if (refresh || timeout)
        begin
            st_nxt.count = st_r.reload;
        end
        else if (st_r.enable)
        begin
            st_nxt.count = st_r.count - 24'h00_0001;
        end
        st_nxt.wdt_rst = timeout;
        if (timeout)
        begin
            irq_set[WRI_IRQ_TIMEOUT] = 1'b1;
        end

        // Causes are sticky until system reset
        cause_set[WRI_CAUSE_WDT] = timeout;
        cause_set[WRI_CAUSE_STOP] = stop_recov_evt;
        cause_set[WRI_CAUSE_EXT] = ext_sync & ~st_r.ext_prev;
        st_nxt.ext_prev = ext_sync;
        st_nxt.cause = st_r.cause | cause_set;

        // Write-one-to-clear; a same-cycle event wins over the clear
        if (wr_ok && idx == WRI_IDX_IRQ_STS)
        begin
            st_nxt.irq_sts = st_r.irq_sts & ~avs_writedata[WRI_IRQ_W-1:0];
        end
        st_nxt.irq_sts = st_nxt.irq_sts | irq_set;
        st_nxt.irq = |(st_r.irq_sts & st_r.irq_msk);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.wait_q <= 1'b1;
            st_r.rdata <= '0;
            st_r.count <= WRI_RELOAD_RST;
            st_r.reload <= WRI_RELOAD_RST;
            st_r.cause <= WRI_CAUSE_RST;
            st_r.key_stage <= 1'b0;
            st_r.unlocked <= 1'b0;
            st_r.enable <= WRI_ENABLE_RST;
            st_r.irq_sts <= '0;
            st_r.irq_msk <= '0;
            st_r.irq <= 1'b0;
            st_r.wdt_rst <= 1'b0;
            st_r.ext_prev <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.wait_q;
    assign wdt_reset_req = st_r.wdt_rst;
    assign irq = st_r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Bus checks assume a master that holds its request until waitrequest is low

    status_read_layout_a:
    assert property (accept && avs_read && idx == WRI_IDX_CTL_STAT
        |-> avs_readdata == {24'h00_0000, $past(st_r.cause), 4'h0})
    else $error("status read does not show causes in bits 7..4");

    ctl_write_cause_a:
    assert property (wr_ok && idx == WRI_IDX_CTL_STAT && cause_set == 4'h0
        |=> st_r.cause == $past(st_r.cause))
    else $error("control write altered the reset status");

    count_read_a:
    assert property (accept && avs_read && idx == WRI_IDX_UPPER
        |-> avs_readdata[7:0] == $past(st_r.count[23:16]))
    else $error("upper byte read is not the live count");

    reload_low_load_a:
    assert property (wr_ok && st_r.unlocked && idx == WRI_IDX_LOW
        |=> st_r.reload[7:0] == $past(avs_writedata[7:0]) && !st_r.unlocked)
    else $error("low reload byte not loaded");

    reserved_idle_a:
    assert property (accept && (idx == WRI_IDX_RSVD0 || idx == WRI_IDX_RSVD1)
        |-> avs_readdata == 32'h0000_0000 ##1 $stable(st_r.reload))
    else $error("reserved location had an effect");

    expiry_reset_a:
    assert property (st_r.enable && st_r.count == 24'h00_0000 && !refresh
        |=> wdt_reset_req && st_r.cause[WRI_CAUSE_WDT] && st_r.count == $past(st_r.reload))
    else $error("expiry did not raise the watchdog reset");

    bus_answer_a:
    assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not given after one wait state");

    irq_level_a:
    assert property (##1 irq == $past(|(st_r.irq_sts & st_r.irq_msk)))
    else $error("interrupt level does not follow masked status");

    stop_cause_set_a:
    assert property (stop_recov_evt
        |=> st_r.cause[WRI_CAUSE_STOP])
    else $error("stop recovery did not set its cause bit");

    ext_cause_set_a:
    assert property ($rose(ext_sync)
        |=> st_r.cause[WRI_CAUSE_EXT])
    else $error("external pin edge did not set its cause bit");

    cause_sticky_a:
    assert property (1'b1
        |=> (st_r.cause & $past(st_r.cause)) == $past(st_r.cause))
    else $error("a reset cause bit cleared without system reset");

    reload_locked_a:
    assert property (wr_ok && !st_r.unlocked
        |=> $stable(st_r.reload))
    else $error("reload changed while locked");

    count_step_a:
    assert property (st_r.enable && st_r.count != 24'h00_0000 && !refresh
        |=> st_r.count == $past(st_r.count) - 24'h00_0001)
    else $error("counter did not step down by one");

    stopped_quiet_a:
    assert property (!st_r.enable
        |=> !wdt_reset_req)
    else $error("watchdog reset raised while the counter is stopped");

    refresh_load_a:
    assert property (refresh
        |=> st_r.count == $past(st_r.reload) && st_r.unlocked)
    else $error("unlock did not refresh the counter");

    bad_key_flag_a:
    assert property (wr_ok && idx == WRI_IDX_CTL_STAT && !st_r.key_stage
        && avs_writedata[7:0] != WRI_KEY_FIRST |=> st_r.irq_sts[WRI_IRQ_BADKEY])
    else $error("wrong unlock key did not raise its flag");

    irq_set_wins_a:
    assert property (irq_set != '0
        |=> (st_r.irq_sts & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost against a clear");

    readdata_idle_a:
    assert property (avs_waitrequest
        |-> avs_readdata == 32'h0000_0000)
    else $error("read data shown outside the answer cycle");

    // ------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------
    timeout_seen_c: cover property (wdt_reset_req);
    count_read_c: cover property (accept && avs_read && idx == WRI_IDX_LOW);
    unlock_done_c: cover property (refresh ##[1:20] wr_ok && idx == WRI_IDX_LOW);
    bad_key_c: cover property (irq_set[WRI_IRQ_BADKEY]);
    all_causes_c: cover property (st_r.cause == 4'hf);
endmodule
`default_nettype wire

//--- verif/wri_top_test.sv
// Self-checking bench for the watchdog register interface top module.
// Assumes the hand-over timing: one wait state per Avalon-MM access.
`timescale 1ns/10ps
`default_nettype none
module wri_top_test
    import wri_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] avs_address = 14'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_reset_pin = 1'b0;
    logic stop_recov_evt = 1'b0;
    logic wdt_reset_req;
    logic irq;
    int bad_count = 0;
    int samples_checked = 0;

    wri_top u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ext_reset_pin(ext_reset_pin),
        .stop_recov_evt(stop_recov_evt),
        .wdt_reset_req(wdt_reset_req),
        .irq(irq)
    );

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------
    // Waitrequest and readdata are taken as they stood just before each rising edge
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdat);
        int n;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= wd;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            bad_count++;
            $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
            end_sim();
        end
    endtask

    task automatic wr8(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, idx, {24'h00_0000, d}, dummy);
    endtask

    task automatic rdchk(input string what, input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        bus(1'b0, idx, 32'h0000_0000, v);
        chk(what, {24'h00_0000, exp}, v);
    endtask

    task automatic unlock();
        wr8(WRI_IDX_CTL_STAT, WRI_KEY_FIRST);
        wr8(WRI_IDX_CTL_STAT, WRI_KEY_SECOND);
    endtask

    task automatic irqchk(input logic exp);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rdchk("status after reset", WRI_IDX_CTL_STAT, 8'h80);
        rdchk("count upper", WRI_IDX_UPPER, 8'h00);
        rdchk("count high", WRI_IDX_HIGH, 8'h03);
        wr8(WRI_IDX_RSVD0, 8'hff);
        wr8(WRI_IDX_RSVD1, 8'hff);
        rdchk("reserved 0", WRI_IDX_RSVD0, 8'h00);
        rdchk("reserved 1", WRI_IDX_RSVD1, 8'h00);
        rdchk("unmapped", 12'h000, 8'h00);
        // Short reload so the expiry comes quickly
        unlock();
        wr8(WRI_IDX_UPPER, 8'h00);
        wr8(WRI_IDX_HIGH, 8'h00);
        wr8(WRI_IDX_LOW, 8'h10);
        unlock();
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (wdt_reset_req !== 1'b1 && n < 200);
        chk("expiry seen", 32'h0, {31'h0, n >= 200});
        if (n >= 200)
            end_sim();
        rdchk("status after expiry", WRI_IDX_CTL_STAT, 8'ha0);
        wr8(WRI_IDX_CTL_STAT, 8'h12);
        rdchk("status after key write", WRI_IDX_CTL_STAT, 8'ha0);
        rdchk("irq status", WRI_IDX_IRQ_STS, 8'h03);
        // Stop the counter so the timeout event cannot come back
        unlock();
        wr8(WRI_IDX_CFG, 8'h00);
        rdchk("cfg enable", WRI_IDX_CFG, 8'h00);
        wr8(WRI_IDX_IRQ_STS, 8'h03);
        rdchk("irq status cleared", WRI_IDX_IRQ_STS, 8'h00);
        wr8(WRI_IDX_IRQ_MSK, 8'h01);
        rdchk("irq mask", WRI_IDX_IRQ_MSK, 8'h01);
        wr8(WRI_IDX_CTL_STAT, 8'h00);
        irqchk(1'b0);
        wr8(WRI_IDX_IRQ_MSK, 8'h02);
        irqchk(1'b1);
        wr8(WRI_IDX_IRQ_STS, 8'h02);
        irqchk(1'b0);
        // A low write relocks, so the second one must be ignored
        wr8(WRI_IDX_LOW, 8'h10);
        wr8(WRI_IDX_LOW, 8'h20);
        unlock();
        rdchk("count after refresh", WRI_IDX_LOW, 8'h10);
        @(posedge core_clk);
        ext_reset_pin <= 1'b1;
        stop_recov_evt <= 1'b1;
        @(posedge core_clk);
        stop_recov_evt <= 1'b0;
        repeat (6) @(posedge core_clk);
        rdchk("status all causes", WRI_IDX_CTL_STAT, 8'hf0);
        end_sim();
    end
endmodule
`default_nettype wire
